// [design/wdt_cfg.svh]
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define WDT_ADDR_W          16
`define WDT_MODE_ADDR       16'hFF49
`define WDT_PERIOD_ADDR     16'hFF4A
`define WDT_MODE_RESET      8'h00
`define WDT_PERIOD_RESET    3'h0

// ****************************************************************
// Field positions
// ****************************************************************
`define WDT_RUN_BIT         7
`define WDT_MODE_HI_BIT     4
`define WDT_MODE_LO_BIT     3
`define WDT_PERIOD_W        3

// ****************************************************************
// Counter and timing
// ****************************************************************
`define WDT_PRESC_W         8
`define WDT_UPPER_W         12
`define WDT_EXP_BASE        12
`define WDT_EXP_LAST        20
`define WDT_PERIOD_LAST     3'h7
`define WDT_VECTOR          16'h0004

`endif

// [design/wdt_pkg.sv]
`include "wdt_cfg.svh"

package wdt_pkg;

  // Operating mode from the two set-only mode bits
  typedef enum logic [1:0] {
    MODE_OFF      = 2'b00,
    MODE_INTERVAL = 2'b01,
    MODE_NMI      = 2'b10,
    MODE_RESET    = 2'b11
  } op_mode_t;

  // Register access request from the CPU side
  typedef struct packed {
    logic                   wr;       // Write strobe
    logic                   rd;       // Read strobe
    logic                   bit_op;   // Single-bit write when high
    logic [2:0]             bit_sel;  // Bit index for single-bit write
    logic [`WDT_ADDR_W-1:0] addr;
    logic [7:0]             wdata;    // Bit writes use wdata[0]
  } reg_req_t;

  // Prescaler state
  typedef struct packed {
    logic [1:0]             sync;     // Two-flop synchroniser
    logic                   last;     // Previous synchronised level
    logic [`WDT_PRESC_W-1:0] count;
  } presc_state_t;

  // Main block state
  typedef struct packed {
    logic                    run;
    logic [1:0]              mode;
    logic [`WDT_PERIOD_W-1:0] period;
    logic [`WDT_UPPER_W-1:0] upper;
    logic                    irq_flag;
    logic                    nmi;
    logic                    sys_rst;
    logic [7:0]              rdata;
  } wdt_state_t;

endpackage : wdt_pkg

// [design/wdt_prescaler.sv]
`timescale 1ns/10ps
`include "wdt_cfg.svh"

module wdt_prescaler
  import wdt_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic sub_clk,   // Subsystem clock pin
  output logic      carry      // One-cycle pulse every 2^8 subsystem periods
);

  presc_state_t st_reg;
  presc_state_t st_next;
  logic         tick;

  // Rising edge of the synchronised subsystem clock
  assign tick  = ce && st_reg.sync[1] && !st_reg.last;
  assign carry = tick && (st_reg.count == {`WDT_PRESC_W{1'b1}});

  // Prescaler runs freely, never cleared by a restart
  always_comb begin
    st_next       = st_reg;
    st_next.sync  = {st_reg.sync[0], sub_clk};
    st_next.last  = st_reg.sync[1];
    if (tick) begin
      st_next.count = st_reg.count + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

endmodule : wdt_prescaler

// [design/watchdog_interval_timer.sv]
// Summary of operation
// R1: Period code 0..7 selects overflow at 2^12..2^18 or 2^20 subsystem periods.
// R2: External reset clears mode and period registers, stopping the count.
// R3: Writing one to the go bit clears the counter and starts counting.
// R4: Software cannot clear the go bit; only reset stops the count.
// R5: Both mode bits are set-only until reset.
// R6: Mode 01 is interval timer with a maskable interrupt each overflow.
// R7: Mode 10 raises a non-maskable interrupt on overflow.
// R8: Mode 11 requests a system reset on overflow.
// R9: Interval counting begins only when the go bit is written to one.
// R10: Interval mode raises the interrupt once every selected period.
// R11: Restart clears upper stages only; prescaler keeps running.
// R12: Software checks the interrupt flag is clear before setting mode bit 4.
// R13: Selecting watchdog mode with the flag already set raises a non-maskable interrupt.
// R14: Watchdog interrupt vector is 0004H.
// R15: Mode register takes bit and byte writes; period register takes byte writes.
// R16: Software rewrites the go bit within each period in watchdog modes.
// R17: Interrupt mask gates only the interval mode request.
// R18: Overflow in interval or mode 10 sets the flag until cleared.
// R19: Mode 00 overflow does nothing; unused bits read zero, ignore writes.
`timescale 1ns/10ps
`include "wdt_cfg.svh"

module watchdog_interval_timer
  import wdt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        sub_clk,
  input  reg_req_t         reg_req,
  output logic      [7:0]  rdata,
  input  wire logic        watchdog_irq_mask,
  input  wire logic        irq_flag_clr,
  output logic             watchdog_irq_flag,
  output logic             watchdog_irq,
  output logic             nmi_req,
  output logic             sys_reset_req,
  output logic      [15:0] watchdog_vector
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wdt_state_t              st_reg;
  wdt_state_t              st_next;
  logic                    carry;
  logic                    ovf;
  logic [`WDT_UPPER_W-1:0] ovf_mask;
  logic [4:0]              exp_sel;
  logic                    mode_wr;
  logic                    period_wr;
  logic [7:0]              mode_wval;
  logic [7:0]              mode_rval;
  logic [7:0]              period_rval;

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  wdt_prescaler u_presc (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .sub_clk (sub_clk),
    .carry   (carry)
  );

  // ****************************************************************
  // Overflow selection
  // ****************************************************************
  // Exponent 12..18 for codes 0..6, 20 for code 7
  assign exp_sel = (st_reg.period == `WDT_PERIOD_LAST) ? 5'(`WDT_EXP_LAST)
                 : 5'(`WDT_EXP_BASE) + 5'(st_reg.period);  // [R1]

  // Mask of upper stages that must all be one before the carry
  genvar gi;
  generate
    for (gi = 0; gi < `WDT_UPPER_W; gi++) begin : g_mask
      assign ovf_mask[gi] = (5'(gi) < (exp_sel - 5'(`WDT_PRESC_W)));  // [R1]
    end
  endgenerate

  // Overflow repeats every period because the counter wraps modulo the mask
  assign ovf = st_reg.run && carry && ((st_reg.upper & ovf_mask) == ovf_mask);  // [R1] [R10]

  // ****************************************************************
  // Register decode
  // ****************************************************************
  assign mode_wr   = ce && reg_req.wr && (reg_req.addr == `WDT_MODE_ADDR);
  assign period_wr = ce && reg_req.wr && !reg_req.bit_op && (reg_req.addr == `WDT_PERIOD_ADDR);  // [R15]

  // Value written to the mode register, byte or single bit
  always_comb begin
    mode_wval = mode_rval;
    if (reg_req.bit_op) begin
      mode_wval[reg_req.bit_sel] = reg_req.wdata[0];  // [R15]
    end else begin
      mode_wval = reg_req.wdata;
    end
  end

  // Read views, unused bits zero
  assign mode_rval   = {st_reg.run, 2'b00, st_reg.mode, 3'b000};  // [R19]
  assign period_rval = {5'b00000, st_reg.period};                 // [R19]

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next     = st_reg;
    st_next.nmi = 1'b0;
    // Upper stages advance on each prescaler carry while running
    if (st_reg.run && carry) begin
      st_next.upper = st_reg.upper + 1'b1;  // [R3]
    end
    if (period_wr) begin
      st_next.period = reg_req.wdata[`WDT_PERIOD_W-1:0];
    end
    if (mode_wr) begin
      st_next.mode[1] = st_reg.mode[1] | mode_wval[`WDT_MODE_HI_BIT];  // [R5]
      st_next.mode[0] = st_reg.mode[0] | mode_wval[`WDT_MODE_LO_BIT];  // [R5]
      if (mode_wval[`WDT_RUN_BIT]) begin
        st_next.run   = 1'b1;  // [R3] [R4] [R9]
        st_next.upper = '0;    // [R11]
      end
      // Late select of a watchdog mode with a pending flag
      if (!st_reg.mode[1] && mode_wval[`WDT_MODE_HI_BIT] && st_reg.irq_flag) begin
        st_next.nmi = 1'b1;  // [R13]
      end
    end
    // Overflow effects per mode
    if (ovf) begin
      case (op_mode_t'(st_reg.mode))
        MODE_INTERVAL: st_next.irq_flag = 1'b1;  // [R6] [R18]
        MODE_NMI: begin
          st_next.irq_flag = 1'b1;  // [R18]
          st_next.nmi      = 1'b1;  // [R7]
        end
        MODE_RESET:    st_next.sys_rst  = 1'b1;  // [R8]
        MODE_OFF:      st_next.sys_rst  = st_reg.sys_rst;  // [R19]
        default:       st_next.sys_rst  = st_reg.sys_rst;
      endcase
    end
    // Set wins over a simultaneous clear
    if (ce && irq_flag_clr && !(ovf && (st_reg.mode == MODE_INTERVAL || st_reg.mode == MODE_NMI))) begin
      st_next.irq_flag = 1'b0;
    end
    // Registered read data
    if (ce && reg_req.rd) begin
      case (reg_req.addr)
        `WDT_MODE_ADDR:   st_next.rdata = mode_rval;
        `WDT_PERIOD_ADDR: st_next.rdata = period_rval;
        default:          st_next.rdata = 8'h00;
      endcase
    end
  end

  // State register, cleared by external reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;  // [R2]
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata             = st_reg.rdata;
  assign watchdog_irq_flag = st_reg.irq_flag;
  assign watchdog_irq      = st_reg.irq_flag && !watchdog_irq_mask && (st_reg.mode == MODE_INTERVAL);  // [R17]
  assign nmi_req           = st_reg.nmi;
  assign sys_reset_req     = st_reg.sys_rst;
  assign watchdog_vector   = `WDT_VECTOR;  // [R14]

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_run_sticky;
    @(posedge clk) disable iff (!rst_b) st_reg.run |=> st_reg.run;
  endproperty
  a_run_sticky: assert property (p_run_sticky) else $error("go bit cleared");  // [R4]

  property p_mode_sticky;
    @(posedge clk) disable iff (!rst_b) ((st_reg.mode & $past(st_reg.mode)) == $past(st_reg.mode));
  endproperty
  a_mode_sticky: assert property (p_mode_sticky) else $error("mode bit cleared");  // [R5]

  property p_stopped;
    @(posedge clk) disable iff (!rst_b) (!st_reg.run && !mode_wr) |=> (st_reg.upper == $past(st_reg.upper));
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");  // [R3]

  property p_restart;
    @(posedge clk) disable iff (!rst_b) (mode_wr && mode_wval[`WDT_RUN_BIT]) |=> (st_reg.run && st_reg.upper == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear counter");  // [R11]

  property p_interval_irq;
    @(posedge clk) disable iff (!rst_b) (ovf && st_reg.mode == MODE_INTERVAL) |=> st_reg.irq_flag;
  endproperty
  a_interval_irq: assert property (p_interval_irq) else $error("interval flag missing");  // [R6]

  property p_nmi_mode;
    @(posedge clk) disable iff (!rst_b) (ovf && st_reg.mode == MODE_NMI) |=> (nmi_req && st_reg.irq_flag);
  endproperty
  a_nmi_mode: assert property (p_nmi_mode) else $error("nmi missing on overflow");  // [R7]

  property p_reset_mode;
    @(posedge clk) disable iff (!rst_b) (ovf && st_reg.mode == MODE_RESET) |=> sys_reset_req [*2];
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset request missing");  // [R8]

  property p_off_mode;
    @(posedge clk) disable iff (!rst_b)
      (ovf && st_reg.mode == MODE_OFF && !mode_wr) |=> (!nmi_req && !sys_reset_req);
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("event in off mode");  // [R19]

  property p_late_nmi;
    @(posedge clk) disable iff (!rst_b)
      (mode_wr && !st_reg.mode[1] && mode_wval[`WDT_MODE_HI_BIT] && st_reg.irq_flag) |=> nmi_req;
  endproperty
  a_late_nmi: assert property (p_late_nmi) else $error("late select nmi missing");  // [R13]

  property p_mask_scope;
    @(posedge clk) disable iff (!rst_b) st_reg.mode[1] |-> !watchdog_irq;
  endproperty
  a_mask_scope: assert property (p_mask_scope) else $error("maskable request in watchdog mode");  // [R17]

endmodule : watchdog_interval_timer

// [dv/irq_partner.sv]
`timescale 1ns/10ps

// ****************************************
// Interrupt controller partner
// ****************************************
module irq_partner (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ack_en,
  input  wire logic watchdog_irq,
  input  wire logic nmi_req,
  output logic      irq_flag_clr,
  output int        nmi_count
);
  // Acknowledge a taken maskable request, count non-maskable pulses
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_flag_clr <= 1'b0;
      nmi_count    <= 0;
    end else begin
      irq_flag_clr <= ack_en && (watchdog_irq === 1'b1) && !irq_flag_clr;
      if (nmi_req === 1'b1) begin
        nmi_count <= nmi_count + 1;
      end
    end
  end
endmodule : irq_partner

// [dv/tb.sv]
`timescale 1ns/10ps
`include "wdt_cfg.svh"

module tb;
  import wdt_pkg::*;
  logic        clk     = 1'b0;
  logic        rst_b   = 1'b0;
  logic        ce      = 1'b1;
  logic        sub_clk = 1'b0;
  logic        mask    = 1'b1;
  logic        ack_en  = 1'b0;
  reg_req_t    reg_req = '0;
  logic        clr, flag, irq, nmi, srst;
  logic [7:0]  rdata, d;
  logic [15:0] vec, a;
  int          nmi_count, n, seed = 32'hB2E3;
  int          failures  = 0;
  int          tests_run = 0;
  time         t0;
  localparam int SUB_CLKS = 3;   // System clocks per subsystem period
  localparam int CLK_NS   = 40;  // System clock period in ns

  // ****************************************
  // Clocks, design and partner
  // ****************************************
  always #20 clk = ~clk;

  // Fast subsystem clock, high for two system clocks and low for one
  always begin
    @(posedge clk);
    sub_clk <= 1'b1;
    repeat (SUB_CLKS - 1) @(posedge clk);
    sub_clk <= 1'b0;
  end

  watchdog_interval_timer watchdog_interval_timer_inst (.clk(clk), .rst_b(rst_b), .ce(ce),
    .sub_clk(sub_clk), .reg_req(reg_req), .rdata(rdata), .watchdog_irq_mask(mask),
    .irq_flag_clr(clr), .watchdog_irq_flag(flag), .watchdog_irq(irq), .nmi_req(nmi),
    .sys_reset_req(srst), .watchdog_vector(vec));

  irq_partner irq_partner_inst (.clk(clk), .rst_b(rst_b), .ack_en(ack_en),
    .watchdog_irq(irq), .nmi_req(nmi), .irq_flag_clr(clr), .nmi_count(nmi_count));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  // Overflow period in subsystem clocks for a period code
  function automatic int exp_ticks(input logic [2:0] code);
    return (code == 3'h7) ? (1 << 20) : (1 << (12 + code));
  endfunction : exp_ticks

  task automatic wr(input logic [15:0] ad, input logic [7:0] dt, input logic b = 1'b0,
                    input logic [2:0] s = 3'h0);
    @(posedge clk);
    reg_req <= '{wr:1'b1, rd:1'b0, bit_op:b, bit_sel:s, addr:ad, wdata:dt};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] ad, input logic [7:0] e, input string m);
    @(posedge clk);
    reg_req <= '{wr:1'b0, rd:1'b1, bit_op:1'b0, bit_sel:3'h0, addr:ad, wdata:8'h00};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    @(negedge clk);
    chk(rdata === e, m);
  endtask : rd

  // Poll flag (0), system reset (1) or a non-maskable pulse (2)
  task automatic wait_on(input int k, input int lim);
    n = 0;
    while (n < lim && !((k == 0 && flag === 1'b1) || (k == 1 && srst === 1'b1)
           || (k == 2 && nmi_count > 0))) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_on

  task automatic close_out;
    $display("counts: %0d compared, %0d failed", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(`WDT_MODE_ADDR, 8'h00, "mode reset");
    rd(`WDT_PERIOD_ADDR, 8'h00, "period reset");
    chk(vec === `WDT_VECTOR, "vector");
    // Every period code with random junk above it, plus unmapped traffic
    for (int i = 0; i < 8; i++) begin
      d = {5'($random(seed)), 3'(i)};
      a = 16'hFF4B + 16'(d);
      wr(`WDT_PERIOD_ADDR, d);
      rd(`WDT_PERIOD_ADDR, {5'h00, 3'(i)}, "period code");
      wr(a, d);
      rd(a, 8'h00, "unmapped read");
    end
    wr(`WDT_PERIOD_ADDR, 8'h00);
    wr(`WDT_PERIOD_ADDR, 8'h01, 1'b1, 3'h1);
    wr(`WDT_MODE_ADDR, 8'h67);
    rd(`WDT_PERIOD_ADDR, 8'h00, "period bit write");
    rd(`WDT_MODE_ADDR, 8'h00, "mode unused bits");
    $display("test registers done");
    // Interval mode through bit writes, then attempts to clear
    wr(`WDT_MODE_ADDR, 8'h01, 1'b1, 3'h3);
    rd(`WDT_MODE_ADDR, 8'h08, "mode bit write");
    wr(`WDT_MODE_ADDR, 8'h01, 1'b1, 3'h7);
    wr(`WDT_MODE_ADDR, 8'h00);
    rd(`WDT_MODE_ADDR, 8'h88, "set-only bits");
    wait_on(0, 16500);
    chk(flag === 1'b1, "first interval");
    chk(irq === 1'b0, "masked request");
    t0 = $time;
    @(posedge clk);
    mask <= 1'b0;
    @(negedge clk);
    chk(irq === 1'b1, "unmasked request");
    ack_en <= 1'b1;
    repeat (3) @(negedge clk);
    chk(flag === 1'b0, "acknowledge clears");
    ack_en <= 1'b0;
    wait_on(0, 16500);
    chk(($time - t0) === exp_ticks(3'h0) * SUB_CLKS * CLK_NS, "interval length");
    $display("test interval done");
    // Watchdog selected with the flag still set, then mode 11 overflow
    wr(`WDT_MODE_ADDR, 8'h01, 1'b1, 3'h4);
    repeat (3) @(negedge clk);
    chk(nmi_count === 1, "late select");
    chk(irq === 1'b0, "no maskable request");
    wait_on(1, 16500);
    chk(srst === 1'b1, "system reset");
    $display("test late select done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    chk(srst === 1'b0 && flag === 1'b0, "outputs reset");
    rd(`WDT_MODE_ADDR, 8'h00, "mode reset again");
    // Mode 00 running: one overflow passes with no event
    wr(`WDT_MODE_ADDR, 8'h80);
    repeat (exp_ticks(3'h0) * SUB_CLKS + 100) @(posedge clk);
    chk(flag === 1'b0 && srst === 1'b0 && nmi_count === 0, "idle mode overflow");
    // Mode 10 with software restarts, then a missed restart
    chk(flag === 1'b0, "flag clear before watchdog select");
    wr(`WDT_MODE_ADDR, 8'h90);
    repeat (2) begin
      repeat (10000) @(posedge clk);
      wr(`WDT_MODE_ADDR, 8'h80);
    end
    chk(nmi_count === 0, "restart holds off");
    wait_on(2, 16500);
    chk(nmi_count === 1 && flag === 1'b1, "watchdog interrupt");
    chk(n >= (exp_ticks(3'h0) - 256) * SUB_CLKS && n <= exp_ticks(3'h0) * SUB_CLKS + 8, "restart window");
    $display("test watchdog done");
    close_out();
  end

  // Cut a hang short
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    close_out();
  end
endmodule : tb
